// ---- design/hardware_standby_sequencer.v ----
// hardware standby sequencer: steers cpu halt, module reset, pin float,
// ram retention and oscillator enable from the standby and reset pins.
// assumes an external supervisor drives deep_halt_n and chip_init_n.
// limitation: the clock settling time is measured by the supervisor;
// this block only waits for the reset rising edge after standby release.
// limitation: ram_enable_bit is not visible here, so an early standby
// with ram still enabled is neither caught nor flagged.
`timescale 1ns/1ps
`include "standby_seq_consts.vh"

module hardware_standby_sequencer (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // pins from the supervisor
  input  wire       deep_halt_n_i,
  input  wire       chip_init_n_i,
  input  wire       boot_sel_1_i,
  input  wire       boot_sel_0_i,
  // controls to the rest of the chip
  output reg        cpu_halt_o,
  output reg        module_reset_o,
  output reg        port_float_o,
  output reg        ram_retain_o,
  output reg        osc_enable_o,
  output reg        cpu_reset_o,
  output reg        standby_o,
  output reg        boot_sel_fault_o
);

  // ==========================================================
  // input synchronisers
  reg        halt_meta_ff;
  reg        halt_sync_ff;
  reg        init_meta_ff;
  reg        init_sync_ff;
  reg        init_prev_ff;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      halt_meta_ff <= 1'h0;
      halt_sync_ff <= 1'h0;
      init_meta_ff <= 1'h0;
      init_sync_ff <= 1'h0;
      init_prev_ff <= 1'h0;
    end else begin
      halt_meta_ff <= deep_halt_n_i;
      halt_sync_ff <= halt_meta_ff;
      init_meta_ff <= chip_init_n_i;
      init_sync_ff <= init_meta_ff;
      init_prev_ff <= init_sync_ff;
    end
  end

  wire init_rise = init_sync_ff & ~init_prev_ff;

  // ==========================================================
  // sequencer
  reg [2:0]               state_ff;
  reg [2:0]               nxt_state;
  reg [`RESET_SEQ_W-1:0]  seq_cnt_ff;
  reg [`RESET_SEQ_W-1:0]  nxt_seq_cnt;
  reg [1:0]               boot_cap_ff;

  always @* begin
    nxt_state   = state_ff;
    nxt_seq_cnt = seq_cnt_ff;
    // raw low level enters standby without waiting for the synchroniser,
    // so pins float even if the clock is about to stop
    if (!deep_halt_n_i) begin
      nxt_state = `ST_HALT;
    end else begin
      case (state_ff)
        `ST_RUN: begin
          if (!init_sync_ff) begin
            nxt_state = `ST_RESET_HELD;
          end
        end
        `ST_HALT: begin
          // release of standby alone restarts the oscillator and ends pin float and ram retention; cpu and modules stay in reset
          if (halt_sync_ff) begin
            nxt_state = `ST_OSC_START;
          end
        end
        `ST_OSC_START: begin
          // wait for reset low then high; supervisor times the settling
          if (init_rise) begin
            nxt_state   = `ST_RESET_SEQ;
            nxt_seq_cnt = `RESET_SEQ_CYCLES;
          end
        end
        `ST_RESET_SEQ: begin
          if (!init_sync_ff) begin
            nxt_state = `ST_RESET_HELD;
          end else if (seq_cnt_ff == {`RESET_SEQ_W{1'b0}}) begin
            nxt_state = `ST_RUN;
          end else begin
            nxt_seq_cnt = seq_cnt_ff - 8'h01;
          end
        end
        `ST_RESET_HELD: begin
          if (init_rise) begin
            nxt_state   = `ST_RESET_SEQ;
            nxt_seq_cnt = `RESET_SEQ_CYCLES;
          end
        end
        default: begin
          nxt_state = `ST_HALT;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff   <= `ST_RESET_HELD;
      seq_cnt_ff <= {`RESET_SEQ_W{1'b0}};
    end else begin
      state_ff   <= nxt_state;
      seq_cnt_ff <= nxt_seq_cnt;
    end
  end

  // ==========================================================
  // state decode helpers
  // one function keeps every state test below written the same way
  function is_state;
    input [2:0] code;
    input [2:0] want;
    begin
      is_state = (code == want);
    end
  endfunction

  wire nxt_halt = is_state(nxt_state, `ST_HALT);
  wire nxt_osc  = is_state(nxt_state, `ST_OSC_START);
  wire nxt_run  = is_state(nxt_state, `ST_RUN);

  // ==========================================================
  // next output values
  // outputs follow the next state, so standby entry shows one edge
  // after the pin falls rather than two
  reg        nxt_cpu_halt;
  reg        nxt_mod_reset;
  reg        nxt_float;
  reg        nxt_retain;
  reg        nxt_osc_en;
  reg        nxt_cpu_reset;
  reg        nxt_standby;

  always @* begin
    nxt_cpu_halt  = 1'h1;
    nxt_mod_reset = 1'h1;
    nxt_float     = 1'h0;
    nxt_retain    = 1'h0;
    nxt_osc_en    = 1'h1;
    nxt_cpu_reset = 1'h1;
    nxt_standby   = 1'h0;
    // every state other than run keeps the cpu and modules in reset
    if (nxt_run) begin
      nxt_cpu_halt  = 1'h0;
      nxt_mod_reset = 1'h0;
      nxt_cpu_reset = 1'h0;
    end else if (nxt_halt) begin
      nxt_float     = 1'h1;
      nxt_retain    = 1'h1;
      nxt_osc_en    = 1'h0;
      nxt_standby   = 1'h1;
    end else if (nxt_osc) begin
      // oscillator runs again but the chip stays in standby and reset
      nxt_standby   = 1'h1;
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cpu_halt_o       <= 1'h1;
      module_reset_o   <= 1'h1;
      port_float_o     <= 1'h0;
      ram_retain_o     <= 1'h0;
      osc_enable_o     <= 1'h1;
      cpu_reset_o      <= 1'h1;
      standby_o        <= 1'h0;
      boot_sel_fault_o <= 1'h0;
      boot_cap_ff      <= 2'h0;
    end else begin
      cpu_halt_o     <= nxt_cpu_halt;
      module_reset_o <= nxt_mod_reset;
      port_float_o   <= nxt_float;
      ram_retain_o   <= nxt_retain;
      osc_enable_o   <= nxt_osc_en;
      cpu_reset_o    <= nxt_cpu_reset;
      standby_o      <= nxt_standby;
      // flag boot select movement while the next state is halt, not during oscillator start; informative only
      if (!nxt_halt) begin
        boot_cap_ff      <= {boot_sel_1_i, boot_sel_0_i};
        boot_sel_fault_o <= 1'h0;
      end else if (boot_cap_ff != {boot_sel_1_i, boot_sel_0_i}) begin
        boot_sel_fault_o <= 1'h1;
      end
    end
  end

endmodule // hardware_standby_sequencer

// ---- design/standby_seq_consts.vh ----
// constants for the hardware standby sequencer
// assumes a single 125 MHz system clock
`ifndef STANDBY_SEQ_CONSTS_VH
`define STANDBY_SEQ_CONSTS_VH

// sequencer state codes
`define ST_RUN        3'h0
`define ST_HALT       3'h1
`define ST_OSC_START  3'h2
`define ST_RESET_SEQ  3'h3
`define ST_RESET_HELD 3'h4

// length of the internal reset sequence after chip_init_n rises, in cycles
`define RESET_SEQ_CYCLES 8'h10
`define RESET_SEQ_W      8

`endif

// ---- verif/standby_seq_chk.sv ----
// checker for the standby sequencer ports
// assumes one clock and sync reset rst_i
`timescale 1ns/1ps
module standby_seq_chk (
  input wire logic sys_clk_i, rst_i, deep_halt_n_i, chip_init_n_i,
  input wire logic boot_sel_1_i, boot_sel_0_i, cpu_halt_o, standby_o,
  input wire logic module_reset_o, port_float_o, ram_retain_o,
  input wire logic osc_enable_o, cpu_reset_o, boot_sel_fault_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // properties
  sequence wake_s; $rose(deep_halt_n_i) && standby_o; endsequence
  sequence run_s; $rose(chip_init_n_i) && osc_enable_o; endsequence
  enter_standby_a: assert property (!deep_halt_n_i |=> standby_o &&
    port_float_o && !osc_enable_o) else $error("entry");
  halt_modules_a: assert property (port_float_o |-> cpu_halt_o &&
    module_reset_o) else $error("halt");
  ram_keep_a: assert property (ram_retain_o == port_float_o)
    else $error("ram");
  osc_wake_a: assert property (wake_s |-> ##[2:6] (osc_enable_o &&
    cpu_reset_o && !port_float_o)) else $error("wake");
  no_resume_a: assert property (standby_o |-> cpu_halt_o)
    else $error("resume");
  run_after_a: assert property (run_s |-> cpu_halt_o [*8] ##[8:18]
    !cpu_halt_o) else $error("run");
  reset_hold_a: assert property (!chip_init_n_i [*5] ##0 !standby_o
    |-> cpu_reset_o) else $error("hold");
  boot_fault_a: assert property (port_float_o && $changed({boot_sel_1_i,
    boot_sel_0_i}) |-> ##[1:3] boot_sel_fault_o) else $error("boot");
endmodule // standby_seq_chk
bind hardware_standby_sequencer standby_seq_chk standby_seq_chk_i (.*);

// ---- verif/supervisor_model.sv ----
// supervisor model: standby, chip reset and boot select pins
// assumes sleep_i is held for many cycles each way
`timescale 1ns/1ps
module supervisor_model #(parameter SETTLE = 20) (
  input  wire       sys_clk_i,
  input  wire       sleep_i,
  input  wire       bad_boot_i,
  output reg        deep_halt_n_o,
  output reg        chip_init_n_o,
  output reg  [1:0] boot_sel_o = 2'h3
);
  // ====
  // reset goes low first; released only after the settle wait
  initial begin
    deep_halt_n_o = 1'h1;
    chip_init_n_o = 1'h1;
    forever begin
      // software has cleared ram_enable_bit before sleep_i rises
      @(posedge sleep_i) #1 chip_init_n_o = 1'h0;
      repeat (6) @(posedge sys_clk_i);
      #1 deep_halt_n_o = 1'h0;
      @(negedge sleep_i) #1 deep_halt_n_o = 1'h1;
      repeat (SETTLE) @(posedge sys_clk_i);
      #1 chip_init_n_o = 1'h1;
    end
  end
  always @(posedge sys_clk_i)
    if (bad_boot_i) boot_sel_o <= ~boot_sel_o;
endmodule // supervisor_model

// ---- verif/tb_top.sv ----
// testbench: model drives the pins, tasks judge the outputs
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 0, rst_i = 1, sleep = 0, bad = 0;
  wire deep_halt_n_i, chip_init_n_i, boot_sel_1_i, boot_sel_0_i;
  wire cpu_halt_o, module_reset_o, port_float_o, ram_retain_o;
  wire osc_enable_o, cpu_reset_o, standby_o, boot_sel_fault_o;
  int fail_count = 0, checked = 0, cyc = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  supervisor_model supervisor_model_i (.sys_clk_i(sys_clk_i),
    .sleep_i(sleep), .bad_boot_i(bad), .deep_halt_n_o(deep_halt_n_i),
    .chip_init_n_o(chip_init_n_i), .boot_sel_o({boot_sel_1_i,
    boot_sel_0_i}));
  hardware_standby_sequencer hardware_standby_sequencer_i (.*);
  // ====
  // shared tasks
  task chk(input logic got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task to_run;
    for (int i = 0; i < 80 && cpu_halt_o !== 1'h0; i++) step(1);
  endtask
  task end_of_test;
    $display("fails %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ====
  // scenarios
  task sleep_wake;
    sleep = 1;
    step(10);
    chk(standby_o, 1'h1);
    chk(port_float_o, 1'h1);
    chk(ram_retain_o, 1'h1);
    chk(module_reset_o, 1'h1);
    sleep = 0;
    step(8);
    chk(osc_enable_o, 1'h1);
    chk(cpu_halt_o, 1'h1);
    to_run;
    chk(cpu_reset_o, 1'h0);
  endtask
  task boot_fault;
    sleep = 1;
    step(10);
    bad = 1;
    step(1);
    bad = 0;
    step(3);
    chk(boot_sel_fault_o, 1'h1);
    sleep = 0;
    to_run;
    chk(boot_sel_fault_o, 1'h0);
  endtask
  initial begin
    step(4);
    rst_i = 0;
    sleep_wake;
    boot_fault;
    end_of_test;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_of_test;
    end
  end
endmodule // tb_top
